//--- rtl/adc_range_coding_refdetect.sv
// Control, coding and reference-detect logic for two sigma-delta converters
`timescale 1ns/100ps
`include "conv_ctrl_params.svh"

module adc_range_coding_refdetect
	import conv_ctrl_pkg::*;
(
	input  wire logic                clk_sys,
	input  wire logic                rst,
	input  wire logic                psel,
	input  wire logic                penable,
	input  wire logic                pwrite,
	input  wire logic [11:0]         paddr,
	input  wire logic [31:0]         pwdata,
	output logic                     pready,
	output logic [31:0]              prdata,
	output logic                     pslverr,
	input  wire conv_evt_t [1:0]     convEvt,
	input  wire logic                refLostPin,
	output gain_range_t              primaryRange,
	output logic [1:0]               unipolarSel,
	output logic [1:0]               extRefSel,
	output cur_route_t               curRoute,
	output logic                     irq
);

	// ----------------------------------------
	// Storage
	// ----------------------------------------
	logic [4:0]                     primCtrl_q;
	logic [1:0]                     auxCtrl_q;
	logic [4:0]                     curCtrl_q;
	logic [`STATUS_EVT_W-1:0]       stat_q;
	logic [`STATUS_EVT_W-1:0]       mask_q;
	logic [15:0]                    data_q [2];
	logic [23:0]                    offCoef_q [2];
	logic [23:0]                    gainCoef_q [2];
	logic [1:0]                     calRefLost_q;
	logic                           refMeta_q;
	logic                           noRef_q;
	logic                           apbAccess;
	logic                           apbDone;
	logic                           statRead;
	logic [31:0]                    rdValue;
	logic                           rdHit;
	logic [`STATUS_EVT_W-1:0]       statSet;
	logic [1:0]                     uniBit;

	// ----------------------------------------
	// Helper functions
	// ----------------------------------------

	// Unipolar clamps below zero; bipolar halves and flips the top bit
	function automatic logic [15:0] encodeResult(input logic [16:0] raw, input logic uni);
		logic [15:0] half;
		half = raw[16:1];
		if (uni) begin
			encodeResult = raw[16] ? 16'h0000 : raw[15:0];
		end else begin
			encodeResult = {~half[15], half[14:0]};
		end
	endfunction : encodeResult

	// Sources landing on a pin, combining doubles the chosen pin
	function automatic logic [1:0] pinCount(input logic [4:0] c, input logic pinTwo);
		pinCount = 2'd0;
		if (c[`CUR_COMBINE_BIT]) begin
			if (c[`CUR_TOPIN2_BIT] == pinTwo) begin
				pinCount = {1'b0, c[`CUR_EXC1_BIT]} + {1'b0, c[`CUR_EXC2_BIT]};
			end
		end else begin
			pinCount = {1'b0, pinTwo ? c[`CUR_EXC2_BIT] : c[`CUR_EXC1_BIT]};
		end
	endfunction : pinCount

	assign uniBit = {auxCtrl_q[`AUX_UNI_BIT], primCtrl_q[`PRIM_UNI_BIT]};

	// ----------------------------------------
	// APB slave, one wait state per access
	// ----------------------------------------
	assign apbAccess = psel & penable;
	assign apbDone   = apbAccess & pready;
	assign statRead  = apbDone & ~pwrite & (paddr == `OFS_STATUS);

	// Read mux; unmapped addresses answer with an error
	always_comb begin
		rdValue = 32'h0000_0000;
		rdHit   = 1'b1;
		if (paddr == `OFS_PRIM_CTRL) begin
			rdValue = {27'h000_0000, primCtrl_q};
		end else if (paddr == `OFS_AUX_CTRL) begin
			rdValue = {30'h0000_0000, auxCtrl_q};
		end else if (paddr == `OFS_CUR_CTRL) begin
			rdValue = {27'h000_0000, curCtrl_q};
		end else if (paddr == `OFS_STATUS) begin
			rdValue = {27'h000_0000, noRef_q, stat_q};
		end else if (paddr == `OFS_IRQ_MASK) begin
			rdValue = {28'h000_0000, mask_q};
		end else if (paddr == `OFS_PRIM_DATA) begin
			rdValue = {16'h0000, data_q[0]};
		end else if (paddr == `OFS_AUX_DATA) begin
			rdValue = {16'h0000, data_q[1]};
		end else if (paddr == `OFS_PRIM_OFFSET) begin
			rdValue = {8'h00, offCoef_q[0]};
		end else if (paddr == `OFS_PRIM_GAIN) begin
			rdValue = {8'h00, gainCoef_q[0]};
		end else if (paddr == `OFS_AUX_OFFSET) begin
			rdValue = {8'h00, offCoef_q[1]};
		end else if (paddr == `OFS_AUX_GAIN) begin
			rdValue = {8'h00, gainCoef_q[1]};
		end else begin
			rdHit = 1'b0;
		end
	end

	// Answer is registered one cycle into the access phase
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			pready  <= 1'b0;
			prdata  <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else if (apbAccess & ~pready) begin
			pready  <= 1'b1;
			prdata  <= pwrite ? 32'h0000_0000 : rdValue;
			pslverr <= ~rdHit;
		end else begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end
	end

	// Control registers written on the completing edge
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			primCtrl_q <= `PRIM_CTRL_RST;
			auxCtrl_q  <= `AUX_CTRL_RST;
			curCtrl_q  <= `CUR_CTRL_RST;
			mask_q     <= `IRQ_MASK_RST;
		end else if (apbDone & pwrite) begin
			if (paddr == `OFS_PRIM_CTRL) begin
				primCtrl_q <= pwdata[4:0];
			end else if (paddr == `OFS_AUX_CTRL) begin
				auxCtrl_q <= pwdata[1:0];
			end else if (paddr == `OFS_CUR_CTRL) begin
				curCtrl_q <= pwdata[4:0];
			end else if (paddr == `OFS_IRQ_MASK) begin
				mask_q <= pwdata[3:0];
			end
		end
	end

	// ----------------------------------------
	// Reference detect
	// ----------------------------------------

	// Comparator is asynchronous to the core, two flops first
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			refMeta_q <= 1'b0;
			noRef_q   <= 1'b0;
		end else begin
			refMeta_q <= refLostPin;
			noRef_q   <= refMeta_q;
		end
	end

	// ----------------------------------------
	// Results, calibration and status
	// ----------------------------------------

	// Latch reference loss seen at any time during a calibration
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			calRefLost_q <= 2'b00;
		end else begin
			for (int i = 0; i < 2; i++) begin
				if (!convEvt[i].calBusy) begin
					calRefLost_q[i] <= 1'b0;
				end else if (noRef_q) begin
					calRefLost_q[i] <= 1'b1;
				end
			end
		end
	end

	// Result registers; a lost reference forces all ones
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			data_q[0] <= `DATA_RST;
			data_q[1] <= `DATA_RST;
		end else begin
			for (int i = 0; i < 2; i++) begin
				if (convEvt[i].convDone) begin
					data_q[i] <= noRef_q ? `DATA_ALL_ONES : encodeResult(convEvt[i].raw, uniBit[i]);
				end
			end
		end
	end

	// Coefficients kept unless the reference held throughout
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			for (int i = 0; i < 2; i++) begin
				offCoef_q[i]  <= `COEF_RST;
				gainCoef_q[i] <= `COEF_RST;
			end
		end else begin
			for (int i = 0; i < 2; i++) begin
				if (convEvt[i].calDone && !calRefLost_q[i] && !noRef_q) begin
					if (convEvt[i].calGain) begin
						gainCoef_q[i] <= convEvt[i].coef;
					end else begin
						offCoef_q[i] <= convEvt[i].coef;
					end
				end
			end
		end
	end

	// Event sources of the sticky status bits
	always_comb begin
		statSet = '0;
		for (int i = 0; i < 2; i++) begin
			statSet[`ST_RDY0_BIT + i] = convEvt[i].convDone | convEvt[i].calDone;
			statSet[`ST_PRIMARY_CAL_ERROR_BIT + i] = convEvt[i].calDone & (calRefLost_q[i] | noRef_q);
		end
	end

	// Sticky status, cleared by a read; a same-cycle event survives
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			stat_q <= '0;
		end else begin
			stat_q <= (statRead ? '0 : stat_q) | statSet;
		end
	end

	// ----------------------------------------
	// Registered outputs to analog and core
	// ----------------------------------------
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			primaryRange <= gain_range_t'(`PRIM_CTRL_RST & 5'h07);
			unipolarSel  <= 2'b10;  // Matches the control reset values, no step after release
			extRefSel    <= 2'b00;
			curRoute     <= '0;
			irq          <= 1'b0;
		end else begin
			primaryRange           <= gain_range_t'(primCtrl_q[`PRIM_RANGE_LSB +: 3]);
			unipolarSel            <= uniBit;
			extRefSel              <= {auxCtrl_q[`AUX_XREF_BIT], primCtrl_q[`PRIM_XREF_BIT]};
			curRoute.burnoutOn     <= curCtrl_q[`CUR_BURNOUT_BIT];
			curRoute.excPinOneCnt  <= pinCount(curCtrl_q, 1'b0);
			curRoute.excPinTwoCnt  <= pinCount(curCtrl_q, 1'b1);
			irq                    <= |(((statRead ? '0 : stat_q) | statSet) & mask_q);
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	force_ones_a: assert property (@(posedge clk_sys) disable iff (rst)
		(convEvt[0].convDone && noRef_q) |=> (data_q[0] == `DATA_ALL_ONES))
		else $error("result not forced to all ones");

	forced_ready_a: assert property (@(posedge clk_sys) disable iff (rst)
		(convEvt[1].convDone && noRef_q && !statRead) |=> stat_q[`ST_RDY1_BIT])
		else $error("forced result did not raise ready");

	uni_coding_a: assert property (@(posedge clk_sys) disable iff (rst)
		(convEvt[0].convDone && !noRef_q && uniBit[0] && convEvt[0].raw == 17'h0_0000)
		|=> (data_q[0] == 16'h0000))
		else $error("unipolar zero not all zeros");

	bip_coding_a: assert property (@(posedge clk_sys) disable iff (rst)
		(convEvt[0].convDone && !noRef_q && !uniBit[0] && convEvt[0].raw == 17'h0_0000)
		|=> (data_q[0] == 16'h8000))
		else $error("bipolar zero not midscale");

	cal_block_a: assert property (@(posedge clk_sys) disable iff (rst)
		(convEvt[0].calDone && calRefLost_q[0]) |=> ($stable(offCoef_q[0]) && $stable(gainCoef_q[0])))
		else $error("coefficient written after reference loss");

	cal_error_a: assert property (@(posedge clk_sys) disable iff (rst)
		(convEvt[1].calDone && calRefLost_q[1] && !statRead) |=> stat_q[`ST_AUX_CAL_ERROR_BIT])
		else $error("calibration error bit not set");

	noref_sync_a: assert property (@(posedge clk_sys) disable iff (rst)
		$rose(refMeta_q) |=> noRef_q)
		else $error("no-reference flag late");

	burnout_follow_a: assert property (@(posedge clk_sys) disable iff (rst)
		(apbDone && pwrite && paddr == `OFS_CUR_CTRL && !pwdata[0]) |-> ##2 !curRoute.burnoutOn)
		else $error("burnout not switched off");

	exc_double_a: assert property (@(posedge clk_sys) disable iff (rst)
		(curCtrl_q == 5'h0E) |=> (curRoute.excPinOneCnt == 2'd2 && curRoute.excPinTwoCnt == 2'd0))
		else $error("excitation not combined on pin one");

	ready_sticky_a: assert property (@(posedge clk_sys) disable iff (rst)
		(stat_q[`ST_RDY0_BIT] && !statRead) |=> stat_q[`ST_RDY0_BIT])
		else $error("ready bit dropped without a read");

endmodule : adc_range_coding_refdetect

//--- rtl/conv_ctrl_params.svh
// Offsets, field positions, reset values and widths of the converter control block
`ifndef CONV_CTRL_PARAMS_SVH
`define CONV_CTRL_PARAMS_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define OFS_PRIM_CTRL    12'h000
`define OFS_AUX_CTRL     12'h004
`define OFS_CUR_CTRL     12'h008
`define OFS_STATUS       12'h00C
`define OFS_IRQ_MASK     12'h010
`define OFS_PRIM_DATA    12'h014
`define OFS_AUX_DATA     12'h018
`define OFS_PRIM_OFFSET  12'h01C
`define OFS_PRIM_GAIN    12'h020
`define OFS_AUX_OFFSET   12'h024
`define OFS_AUX_GAIN     12'h028

// ----------------------------------------
// Field positions
// ----------------------------------------
`define PRIM_RANGE_LSB   0
`define PRIM_UNI_BIT     3
`define PRIM_XREF_BIT    4
`define AUX_UNI_BIT      0
`define AUX_XREF_BIT     1
`define CUR_BURNOUT_BIT  0
`define CUR_EXC1_BIT     1
`define CUR_EXC2_BIT     2
`define CUR_COMBINE_BIT  3
`define CUR_TOPIN2_BIT   4
`define ST_RDY0_BIT      0
`define ST_RDY1_BIT      1
`define ST_PRIMARY_CAL_ERROR_BIT      2
`define ST_AUX_CAL_ERROR_BIT      3
`define ST_NOREF_BIT     4

// ----------------------------------------
// Reset values and widths
// ----------------------------------------
`define PRIM_CTRL_RST    5'h07
`define AUX_CTRL_RST     2'h1
`define CUR_CTRL_RST     5'h00
`define IRQ_MASK_RST     4'h0
`define DATA_RST         16'h0000
`define DATA_ALL_ONES    16'hFFFF
`define COEF_RST         24'h80_0000
`define STATUS_EVT_W     4

`endif

//--- rtl/conv_ctrl_pkg.sv
// Types shared by the converter control block and its surroundings
package conv_ctrl_pkg;

	// Gain ranges of the primary converter, 20 mV up to 2.56 V
	typedef enum logic [2:0] {
		RANGE_20MV,
		RANGE_40MV,
		RANGE_80MV,
		RANGE_160MV,
		RANGE_320MV,
		RANGE_640MV,
		RANGE_1V28,
		RANGE_2V56
	} gain_range_t;

	// Events and data from one converter's datapath, same clock
	typedef struct packed {
		logic        convDone;  // One-cycle pulse, raw holds a result
		logic        calBusy;   // Level, calibration in progress
		logic        calDone;   // One-cycle pulse, coefficient ready
		logic        calGain;   // 1 gain, 0 offset calibration
		logic [16:0] raw;       // Signed filter word, +-full scale
		logic [23:0] coef;      // Coefficient measured by calibration
	} conv_evt_t;

	// Current source routing towards the analog pads
	typedef struct packed {
		logic       burnoutOn;
		logic [1:0] excPinOneCnt;  // Sources on pin one, 0..2
		logic [1:0] excPinTwoCnt;  // Sources on pin two, 0..2
	} cur_route_t;

endpackage : conv_ctrl_pkg

//--- sim/adc_range_coding_refdetect_bench.sv
// Self-checking testbench for the converter control and reference-detect block
`timescale 1ns/100ps
`include "conv_ctrl_params.svh"

module adc_range_coding_refdetect_bench
	import conv_ctrl_pkg::*;
;
	// ----------------------------------------
	// Signals
	// ----------------------------------------
	logic             clk_sys, rst, psel, penable, pwrite, pready, pslverr, refLostPin, irq, err;
	logic [11:0]      paddr;
	logic [31:0]      pwdata, prdata, rd, d, a;
	logic [16:0]      r;
	logic [31:0]      coefExp [4];
	conv_evt_t [1:0]  convEvt;
	gain_range_t      primaryRange;
	logic [1:0]       unipolarSel, extRefSel;
	cur_route_t       curRoute;
	int               nFail, nTests, seed;

	adc_range_coding_refdetect i_adc_range_coding_refdetect (
		.clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
		.convEvt(convEvt), .refLostPin(refLostPin), .primaryRange(primaryRange),
		.unipolarSel(unipolarSel), .extRefSel(extRefSel), .curRoute(curRoute), .irq(irq));

	// Free-running core clock, 100 MHz
	always #5 clk_sys = ~clk_sys;

	// ----------------------------------------
	// Compare, expectation and bus tasks
	// ----------------------------------------
	task chkWord(input logic [31:0] got, input logic [31:0] exp);
		nTests++;
		if (got !== exp) begin
			nFail++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chkWord

	task chkBit(input logic got, input logic exp);
		nTests++;
		if (got !== exp) begin
			nFail++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chkBit

	// Straight binary when unipolar, offset binary otherwise
	function automatic logic [15:0] code(input logic uni, input logic [16:0] raw);
		if (uni) return raw[16] ? 16'h0000 : raw[15:0];
		return {~raw[16], raw[15:1]};
	endfunction : code

	// Both sources onto one pin doubles the count there
	function automatic logic [4:0] route(input logic [4:0] v);
		logic [1:0] n;
		n = 2'(v[1]) + 2'(v[2]);
		if (!v[3]) return {v[0], 1'b0, v[1], 1'b0, v[2]};
		return v[4] ? {v[0], 2'b00, n} : {v[0], n, 2'b00};
	endfunction : route

	// One APB transfer; starts on its own edge so strobes never toggle twice in a step
	task apb(input logic w, input logic [11:0] ad, input logic [31:0] wd);
		int k;
		k = 0;
		@(posedge clk_sys);
		psel <= 1'b1; pwrite <= w; paddr <= ad; pwdata <= wd;
		@(posedge clk_sys);
		penable <= 1'b1;
		do begin
			@(posedge clk_sys);
			k++;
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		chkWord(32'(k), 32'h0000_0002);
		psel <= 1'b0; penable <= 1'b0;
	endtask : apb

	// Result pulse; raw is scrambled afterwards so stale data cannot pass
	task conv(input int i, input logic [16:0] rw);
		@(posedge clk_sys);
		convEvt[i].convDone <= 1'b1; convEvt[i].raw <= rw;
		@(posedge clk_sys);
		convEvt[i].convDone <= 1'b0; convEvt[i].raw <= ~rw;
	endtask : conv

	task cal(input int i, input logic g, input logic lost, input logic [23:0] c);
		@(posedge clk_sys);
		convEvt[i].calBusy <= 1'b1; convEvt[i].calGain <= g; refLostPin <= lost;
		repeat (4) @(posedge clk_sys);
		convEvt[i].calDone <= 1'b1; convEvt[i].coef <= c;
		@(posedge clk_sys);
		convEvt[i].calDone <= 1'b0; convEvt[i].calBusy <= 1'b0; convEvt[i].coef <= ~c; refLostPin <= 1'b0;
		repeat (3) @(posedge clk_sys);
		if (!lost) coefExp[i*2+g] = {8'h00, c};
	endtask : cal

	task chkCoefs;
		for (int i = 0; i < 4; i++) begin
			apb(1'b0, 12'(`OFS_PRIM_OFFSET + 4*i), 32'h0000_0000);
			chkWord(rd, coefExp[i]);
		end
	endtask : chkCoefs

	task conclude;
		$display("comparisons %0d mismatches %0d", nTests, nFail);
		if (nFail == 0 && nTests > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : conclude

	// Watchdog, far beyond the thousand or so cycles the run needs
	initial begin
		#200us;
		nFail++;
		conclude();
	end

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		clk_sys = 1'b0; rst = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
		paddr = 12'h000; pwdata = 32'h0000_0000; convEvt = '0; refLostPin = 1'b0;
		nFail = 0; nTests = 0; seed = 50880;
		coefExp = '{default: 32'h0080_0000};
		repeat (4) @(posedge clk_sys);
		rst <= 1'b0;
		@(posedge clk_sys);
		chkWord(32'(primaryRange), 32'h0000_0007);
		chkWord(32'({unipolarSel, extRefSel}), 32'h0000_0008);
		chkWord(32'(curRoute), 32'h0000_0000);
		chkCoefs();
		// Every range twice, primary bipolar then unipolar, corner and random results
		for (int n = 0; n < 16; n++) begin
			d = ($random(seed) & 32'hFFFF_FFF0) | 32'(n);
			a = $random(seed);
			apb(1'b1, `OFS_PRIM_CTRL, d);
			apb(1'b1, `OFS_AUX_CTRL, a);
			apb(1'b0, `OFS_PRIM_CTRL, 32'h0000_0000);
			chkWord(rd, d & 32'h0000_001F);
			apb(1'b0, `OFS_AUX_CTRL, 32'h0000_0000);
			chkWord(rd, a & 32'h0000_0003);
			chkWord(32'(primaryRange), 32'(d[2:0]));
			chkWord(32'({unipolarSel, extRefSel}), 32'({a[0], d[3], a[1], d[4]}));
			for (int i = 0; i < 2; i++) begin
				case (n % 8)
					0: r = 17'h1_0000;
					1: r = 17'h0_0000;
					2: r = 17'h0_FFFF;
					3: r = 17'h0_8000;
					default: r = 17'($random(seed));
				endcase
				conv(i, r);
				apb(1'b0, i ? `OFS_AUX_DATA : `OFS_PRIM_DATA, 32'h0000_0000);
				chkWord(rd, 32'(code(i ? a[0] : d[3], r)));
			end
		end
		// All current source settings
		for (int v = 0; v < 32; v++) begin
			apb(1'b1, `OFS_CUR_CTRL, 32'(v));
			repeat (2) @(posedge clk_sys);
			chkWord(32'(curRoute), 32'(route(5'(v))));
		end
		// Unmapped address
		apb(1'b1, 12'h02C, 32'hFFFF_FFFF);
		chkBit(err, 1'b1);
		apb(1'b0, 12'h02C, 32'h0000_0000);
		chkWord({rd[31:1], err}, 32'h0000_0001);
		// Reference loss forces all ones and still raises ready
		apb(1'b0, `OFS_STATUS, 32'h0000_0000);
		refLostPin <= 1'b1;
		repeat (3) @(posedge clk_sys);
		apb(1'b0, `OFS_STATUS, 32'h0000_0000);
		chkBit(rd[4], 1'b1);
		for (int i = 0; i < 2; i++) begin
			conv(i, 17'h0_0005);
			apb(1'b0, i ? `OFS_AUX_DATA : `OFS_PRIM_DATA, 32'h0000_0000);
			chkWord(rd, 32'h0000_FFFF);
			apb(1'b0, `OFS_STATUS, 32'h0000_0000);
			chkWord(rd & 32'h0000_0013, 32'h0000_0010 | 32'(1 << i));
		end
		refLostPin <= 1'b0;
		repeat (3) @(posedge clk_sys);
		apb(1'b0, `OFS_STATUS, 32'h0000_0000);
		chkBit(rd[4], 1'b0);
		// Offset and gain calibration, with and without reference
		for (int k = 0; k < 8; k++) begin
			cal(k[0], k[1], k[2], 24'($random(seed)));
			apb(1'b0, `OFS_STATUS, 32'h0000_0000);
			chkWord(rd & 32'h0000_000F, 32'((1 << k[0]) | (k[2] << (2 + k[0]))));
			chkCoefs();
		end
		// Interrupt masked, unmasked and cleared by the status read
		apb(1'b1, `OFS_IRQ_MASK, 32'h0000_0001);
		conv(1, 17'h0_1234);
		repeat (2) @(posedge clk_sys);
		chkBit(irq, 1'b0);
		conv(0, 17'h0_1234);
		repeat (2) @(posedge clk_sys);
		chkBit(irq, 1'b1);
		apb(1'b0, `OFS_STATUS, 32'h0000_0000);
		repeat (2) @(posedge clk_sys);
		chkBit(irq, 1'b0);
		conclude();
	end

endmodule : adc_range_coding_refdetect_bench
